// File: design/nvmac_pkg.sv
// Shared constants and carrier types for the nonvolatile access controller
package nvmac_pkg;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned PROG_ATOMIC_US = 3400; // Erase plus write
  localparam int unsigned PROG_SPLIT_US = 1800; // Erase only or write only
  localparam int unsigned PROG_ATOMIC_CYC = (PROG_ATOMIC_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROG_SPLIT_CYC = (PROG_SPLIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] ARM_WINDOW_CYC = 3'h4;
  localparam logic [2:0] HALT_PROG_CYC = 3'h2;
  localparam logic [2:0] HALT_READ_CYC = 3'h4;

  // ****************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************
  localparam logic [7:0] IDX_CONTROL = 8'h1c;
  localparam logic [7:0] IDX_DATA = 8'h1d;
  localparam logic [7:0] IDX_ADDR = 8'h1e;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ****************************************************
  // Interrupt status layout and reset values
  // ****************************************************
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_REFUSED_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [1:0] {
    MODE_ATOMIC = 2'h0,
    MODE_ERASE = 2'h1,
    MODE_WRITE = 2'h2,
    MODE_RSVD = 2'h3
  } nvmac_mode_e;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] rsvd;
    nvmac_mode_e prog_mode_bits;
    logic ready_irq_enable;
    logic program_arm;
    logic program_start_busy;
    logic read_strobe;
  } nvmac_ctl_s;

  // Signals toward the byte array
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic erase;
    logic write;
    logic read;
  } nvmac_arr_s;

endpackage

// File: design/nvmac_top.sv
// Nonvolatile byte array access controller with an AHB-Lite register slave
// How it works
// - Control word at index 0x1C: mode 5:4, irq enable 3, arm 2, start 1, read 0.
// - Mode 00 erase+write 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms, 11 reserved.
// - Mode writes are ignored while programming is busy.
// - Reset clears the mode bits unless programming is still running.
// - Ready interrupt rises with enable and global flag while the array is ready.
// - Start only succeeds within four clocks after the arm bit was set.
// - Hardware clears the arm bit four clocks after it was set.
// - Start written with arm clear starts nothing; when idle it sets the refused status bit.
// - An accepted start halts the core for two cycles.
// - Busy stays set for the whole mode time, then hardware clears it.
// - Programming blocks flash, fuse and lock programming by software.
// - Read strobe loads the addressed byte into the data register at once.
// - Each read halts the core for four cycles.
// - No reads and no address changes while programming runs.
// - Data register feeds writes and receives read bytes.
// - Address is linear, bits 6:0 used, bit 7 reads zero.
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module nvmac_top #(
  parameter int unsigned ADDR_W = 7,
  parameter int unsigned ATOMIC_CYC = nvmac_pkg::PROG_ATOMIC_CYC,
  parameter int unsigned SPLIT_CYC = nvmac_pkg::PROG_SPLIT_CYC
) (
  input wire logic CLK_SYS, // System clock, 25 MHz
  input wire logic RST_N, // System reset, async, active low
  input wire logic POR_N, // Power-on reset, async, active low
  input wire logic HSEL, // Slave select
  input wire logic [31:0] HADDR, // Byte address
  input wire logic [1:0] HTRANS, // Transfer type
  input wire logic HWRITE, // Write when high
  input wire logic [2:0] HSIZE, // Transfer size
  input wire logic [31:0] HWDATA, // Write data
  input wire logic HREADY, // Bus ready
  output logic [31:0] HRDATA, // Read data
  output logic HREADYOUT, // Slave ready
  output logic HRESP, // Always OKAY
  input wire logic GIE, // Global interrupt flag from the core
  input wire logic [7:0] ARR_RDATA, // Array byte at ARR.addr
  output var nvmac_pkg::nvmac_arr_s ARR, // Array controls
  output logic CPU_HALT, // Core halt request
  output logic PROG_BLOCK, // Blocks other software programming
  output logic READY_IRQ, // Array ready interrupt level
  output logic IRQ // Event interrupt level
);

  // ****************************************************
  // Declarations
  // ****************************************************
  typedef enum logic {ST_IDLE, ST_PROG} nvmac_st_e;
  localparam int CNT_W = $clog2(ATOMIC_CYC + 1);
  localparam logic [7:0] ADDR_MASK = 8'((9'h1 << ADDR_W) - 9'h1);
  localparam logic [CNT_W-1:0] ATOMIC_LOAD = CNT_W'(ATOMIC_CYC);
  localparam logic [CNT_W-1:0] SPLIT_LOAD = CNT_W'(SPLIT_CYC);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  nvmac_st_e state_q;
  logic [CNT_W-1:0] prog_cnt_q;
  nvmac_pkg::nvmac_mode_e mode_q;
  nvmac_pkg::nvmac_arr_s arr_q;
  logic [1:0] rst_sync_q;
  logic rie_q;
  logic arm_q;
  logic [2:0] arm_cnt_q;
  logic [2:0] halt_cnt_q;
  logic [2:0] halt_cnt_d;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] idx_q;
  logic [31:0] hrdata_q;
  logic hready_q;
  logic [nvmac_pkg::IRQ_W-1:0] stat_q;
  logic [nvmac_pkg::IRQ_W-1:0] stat_d;
  logic [nvmac_pkg::IRQ_W-1:0] mask_q;
  logic halt_q;
  logic block_q;
  logic rdy_irq_q;
  logic irq_q;
  nvmac_pkg::nvmac_ctl_s ctl_w;
  nvmac_pkg::nvmac_ctl_s ctl_rd;
  logic addr_ok;
  logic ctl_wr;
  logic start_ok;
  logic start_bad;
  logic rd_ok;
  logic arm_set;
  logic prog_end;
  logic rst_hold;
  logic [7:0] rd_val;

  // ****************************************************
  // Bus decode and strobes
  // ****************************************************
  // Writes land at the edge that closes their data phase
  always_comb begin
    addr_ok = HSEL && HTRANS[1] && HREADY && (HADDR[31:10] == 22'h0);
    ctl_w = nvmac_pkg::nvmac_ctl_s'(HWDATA[7:0]);
    ctl_wr = wr_pend_q && (idx_q == nvmac_pkg::IDX_CONTROL);
    arm_set = ctl_wr && ctl_w.program_arm;
    // Reserved mode refuses the start rather than guessing an operation
    start_ok = ctl_wr && ctl_w.program_start_busy && arm_q && (state_q == ST_IDLE)
               && (ctl_w.prog_mode_bits != nvmac_pkg::MODE_RSVD);
    start_bad = ctl_wr && ctl_w.program_start_busy && (state_q == ST_IDLE) && !start_ok;
    // A start in the same word wins over the read strobe
    rd_ok = ctl_wr && ctl_w.read_strobe && !ctl_w.program_start_busy
            && (state_q == ST_IDLE);
    prog_end = (state_q == ST_PROG) && (prog_cnt_q == CNT_ONE);
    rst_hold = !rst_sync_q[1];
  end

  // Control word as software sees it; strobe bit and top bits read zero
  always_comb begin
    ctl_rd = '0;
    ctl_rd.prog_mode_bits = mode_q;
    ctl_rd.ready_irq_enable = rie_q;
    ctl_rd.program_arm = arm_q;
    ctl_rd.program_start_busy = (state_q == ST_PROG);
    case (idx_q)
      nvmac_pkg::IDX_CONTROL: rd_val = ctl_rd;
      nvmac_pkg::IDX_DATA: rd_val = arr_q.wdata;
      nvmac_pkg::IDX_ADDR: rd_val = arr_q.addr;
      nvmac_pkg::IDX_IRQ_STAT: rd_val = 8'(stat_q);
      nvmac_pkg::IDX_IRQ_MASK: rd_val = 8'(mask_q);
      default: rd_val = 8'h00;
    endcase
  end

  // ****************************************************
  // AHB-Lite slave
  // ****************************************************
  // Reads take one wait state so a read right after a write sees it
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q <= 8'h00;
      hrdata_q <= 32'h0;
      hready_q <= 1'b1;
    end else begin
      wr_pend_q <= addr_ok && HWRITE && (HSIZE == nvmac_pkg::HSIZE_WORD);
      rd_pend_q <= addr_ok && !HWRITE;
      hready_q <= !(addr_ok && !HWRITE);
      if (addr_ok) begin
        idx_q <= HADDR[9:2];
      end
      if (rd_pend_q) begin
        hrdata_q <= {24'h0, rd_val};
      end
    end
  end

  // ****************************************************
  // Reset release detector
  // ****************************************************
  // Two flops since the reset pin is asynchronous to the clock
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // ****************************************************
  // Programming sequencer
  // ****************************************************
  // Only power-on clears it, so a running operation outlives system reset
  always_ff @(posedge CLK_SYS or negedge POR_N) begin
    if (!POR_N) begin
      state_q <= ST_IDLE;
      prog_cnt_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_ok && !rst_hold) begin
            state_q <= ST_PROG;
            if (ctl_w.prog_mode_bits == nvmac_pkg::MODE_ATOMIC) begin
              prog_cnt_q <= ATOMIC_LOAD;
            end else begin
              prog_cnt_q <= SPLIT_LOAD;
            end
          end
        end
        ST_PROG: begin
          prog_cnt_q <= prog_cnt_q - CNT_ONE;
          if (prog_end) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Mode bits: frozen while busy, cleared by system reset only when idle
  always_ff @(posedge CLK_SYS or negedge POR_N) begin
    if (!POR_N) begin
      mode_q <= nvmac_pkg::MODE_ATOMIC;
    end else if (state_q == ST_IDLE) begin
      if (rst_hold) begin
        mode_q <= nvmac_pkg::MODE_ATOMIC;
      end else if (ctl_wr) begin
        mode_q <= ctl_w.prog_mode_bits;
      end
    end
  end

  // ****************************************************
  // Array side: address, data and strobes
  // ****************************************************
  // Data and address hold the source of a write, so they freeze while busy
  always_ff @(posedge CLK_SYS or negedge POR_N) begin
    if (!POR_N) begin
      arr_q <= '0;
      arr_q.wdata <= nvmac_pkg::DATA_RESET;
    end else begin
      arr_q.read <= rd_ok && !rst_hold;
      if (wr_pend_q && (idx_q == nvmac_pkg::IDX_ADDR) && (state_q == ST_IDLE)) begin
        arr_q.addr <= HWDATA[7:0] & ADDR_MASK;
      end
      if (rd_ok && !rst_hold) begin
        arr_q.wdata <= ARR_RDATA;
      end else if (wr_pend_q && (idx_q == nvmac_pkg::IDX_DATA) && (state_q == ST_IDLE)) begin
        arr_q.wdata <= HWDATA[7:0];
      end
      if (start_ok && !rst_hold) begin
        arr_q.erase <= (ctl_w.prog_mode_bits != nvmac_pkg::MODE_WRITE);
        arr_q.write <= (ctl_w.prog_mode_bits != nvmac_pkg::MODE_ERASE);
      end else if (prog_end) begin
        arr_q.erase <= 1'b0;
        arr_q.write <= 1'b0;
      end
    end
  end

  // ****************************************************
  // Arm window and core halt
  // ****************************************************
  // Writing zero to arm does not clear it; only the window expiry or a system reset does
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      arm_cnt_q <= 3'h0;
      arm_q <= 1'b0;
    end else if (arm_set) begin
      arm_cnt_q <= nvmac_pkg::ARM_WINDOW_CYC;
      arm_q <= 1'b1;
    end else if (arm_cnt_q != 3'h0) begin
      arm_cnt_q <= arm_cnt_q - 3'h1;
      arm_q <= (arm_cnt_q != 3'h1);
    end
  end

  // Halt length depends on the operation just launched
  always_comb begin
    if (start_ok) begin
      halt_cnt_d = nvmac_pkg::HALT_PROG_CYC;
    end else if (rd_ok) begin
      halt_cnt_d = nvmac_pkg::HALT_READ_CYC;
    end else if (halt_cnt_q != 3'h0) begin
      halt_cnt_d = halt_cnt_q - 3'h1;
    end else begin
      halt_cnt_d = 3'h0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      halt_cnt_q <= 3'h0;
      halt_q <= 1'b0;
    end else begin
      halt_cnt_q <= halt_cnt_d;
      halt_q <= (halt_cnt_d != 3'h0);
    end
  end

  // ****************************************************
  // Interrupts
  // ****************************************************
  // Reading status clears it, but an event in that same cycle survives
  always_comb begin
    stat_d = stat_q;
    if (rd_pend_q && (idx_q == nvmac_pkg::IDX_IRQ_STAT)) begin
      stat_d = '0;
    end
    stat_d[nvmac_pkg::IRQ_DONE_BIT] = stat_d[nvmac_pkg::IRQ_DONE_BIT] | prog_end;
    stat_d[nvmac_pkg::IRQ_REFUSED_BIT] = stat_d[nvmac_pkg::IRQ_REFUSED_BIT] | start_bad;
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      stat_q <= '0;
      mask_q <= nvmac_pkg::IRQ_MASK_RESET;
      rie_q <= 1'b0;
      irq_q <= 1'b0;
      rdy_irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q <= |(stat_d & mask_q);
      if (wr_pend_q && (idx_q == nvmac_pkg::IDX_IRQ_MASK)) begin
        mask_q <= HWDATA[nvmac_pkg::IRQ_W-1:0];
      end
      if (ctl_wr) begin
        rie_q <= ctl_w.ready_irq_enable;
      end
      // A level, so it repeats until software clears the enable
      rdy_irq_q <= rie_q && GIE && (state_q == ST_IDLE);
    end
  end

  // Busy copy that gates flash, fuse and lock programming elsewhere
  always_ff @(posedge CLK_SYS or negedge POR_N) begin
    if (!POR_N) begin
      block_q <= 1'b0;
    end else begin
      block_q <= (start_ok && !rst_hold) || ((state_q == ST_PROG) && !prog_end);
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign HRDATA = hrdata_q;
  assign HREADYOUT = hready_q;
  assign HRESP = 1'b0;
  assign ARR = arr_q;
  assign CPU_HALT = halt_q;
  assign PROG_BLOCK = block_q;
  assign READY_IRQ = rdy_irq_q;
  assign IRQ = irq_q;

  // ****************************************************
  // Assertions
  // ****************************************************
  a_mode_frozen: assert property (@(posedge CLK_SYS) disable iff (!POR_N)
    (state_q == ST_PROG) |=> $stable(mode_q)) else $error("mode changed while busy");
  a_no_unarmed_start: assert property (@(posedge CLK_SYS) disable iff (!RST_N || !POR_N)
    (ctl_wr && ctl_w.program_start_busy && !arm_q && state_q == ST_IDLE)
    |=> (state_q == ST_IDLE)) else $error("start taken without arm");
  a_arm_window: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    arm_set |=> arm_q [*4]) else $error("arm window shorter than four");
  a_arm_expire: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (arm_cnt_q == 3'h1 && !arm_set) |=> !arm_q) else $error("arm not cleared");
  a_halt_prog: assert property (@(posedge CLK_SYS) disable iff (!RST_N || !POR_N)
    start_ok |=> CPU_HALT [*2]) else $error("start halt too short");
  a_halt_read: assert property (@(posedge CLK_SYS) disable iff (!RST_N || !POR_N)
    rd_ok |=> CPU_HALT [*4]) else $error("read halt too short");
  a_busy_held: assert property (@(posedge CLK_SYS) disable iff (!POR_N)
    (state_q == ST_PROG && prog_cnt_q > CNT_ONE) |=> (state_q == ST_PROG && PROG_BLOCK))
    else $error("busy ended early");
  a_busy_load: assert property (@(posedge CLK_SYS) disable iff (!RST_N || !POR_N || rst_hold)
    (start_ok && ctl_w.prog_mode_bits == nvmac_pkg::MODE_ATOMIC) |=> (prog_cnt_q == ATOMIC_LOAD))
    else $error("wrong atomic time");
  a_addr_frozen: assert property (@(posedge CLK_SYS) disable iff (!POR_N)
    (state_q == ST_PROG) |=> $stable(arr_q.addr)) else $error("address moved while busy");
  a_read_data: assert property (@(posedge CLK_SYS) disable iff (!RST_N || !POR_N || rst_hold)
    rd_ok |=> (ARR.wdata == $past(ARR_RDATA) && ARR.read)) else $error("read byte not captured");
  a_ready_level: assert property (@(posedge CLK_SYS) disable iff (!RST_N || !POR_N)
    READY_IRQ |-> $past(rie_q && GIE && state_q == ST_IDLE)) else $error("ready irq without cause");

endmodule

`default_nettype wire

// File: testbench/nvmac_arr_model.sv
// Behavioural model of the byte array behind the access controller
`timescale 1ns/100ps
`default_nettype none

module nvmac_arr_model (
  input wire logic clk, // System clock
  input wire nvmac_pkg::nvmac_arr_s arr, // Controls from the controller
  output logic [7:0] rdata // Byte at arr.addr
);
  logic [7:0] mem [0:255];

  // Known pattern, so the bench can predict every byte it reads back
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end

  // Read path is combinational, as the controller samples it in the strobe cycle
  assign rdata = mem[arr.addr];

  // Controls are levels held for the whole operation; each action is idempotent, so reapplying is harmless
  always @(posedge clk) begin
    if (arr.erase && arr.write) begin
      mem[arr.addr] <= arr.wdata;
    end else if (arr.erase) begin
      mem[arr.addr] <= 8'hff;
    end else if (arr.write) begin
      mem[arr.addr] <= mem[arr.addr] & arr.wdata;
    end
  end
endmodule

`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the nonvolatile access controller
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  // ****************************************************
  // Signals and counters
  // ****************************************************
  localparam int unsigned AT = 40; // Short programming times keep the run brief
  localparam int unsigned SP = 20;
  localparam logic [7:0] CTL = nvmac_pkg::IDX_CONTROL;
  localparam logic [31:0] NOARM = 32'hffff_fffb; // Arm may lapse while a read is under way
  logic CLK_SYS, RST_N, POR_N, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, GIE;
  logic CPU_HALT, PROG_BLOCK, READY_IRQ, IRQ;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic [31:0] HADDR, HWDATA, HRDATA;
  logic [7:0] ARR_RDATA;
  nvmac_pkg::nvmac_arr_s ARR;
  int error_cnt, n_compared, cyc, halt_n, blk_n, rd_n;
  assign HREADY = HREADYOUT; // The one slave drives the bus ready

  nvmac_top #(.ATOMIC_CYC(AT), .SPLIT_CYC(SP)) DUT (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .POR_N(POR_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .GIE(GIE), .ARR_RDATA(ARR_RDATA), .ARR(ARR),
    .CPU_HALT(CPU_HALT), .PROG_BLOCK(PROG_BLOCK), .READY_IRQ(READY_IRQ), .IRQ(IRQ)
  );
  nvmac_arr_model u_arr (.clk(CLK_SYS), .arr(ARR), .rdata(ARR_RDATA));

  // Clock at 25 MHz
  initial begin
    CLK_SYS = 1'b0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // Pulse counters sample mid-cycle, away from the edge where the main flow clears them
  always @(negedge CLK_SYS) begin
    halt_n += int'(CPU_HALT === 1'b1);
    blk_n += int'(PROG_BLOCK === 1'b1);
    rd_n += int'(ARR.read === 1'b1);
  end

  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One single transfer: address phase held until ready, then the data phase until ready
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HSIZE <= nvmac_pkg::HSIZE_WORD;
    HADDR <= {22'h0, idx, 2'h0};
    do @(posedge CLK_SYS); while (HREADY !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge CLK_SYS); while (HREADY !== 1'b1);
    rd = HRDATA;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask

  task automatic rdchk(input string what, input logic [7:0] idx, input logic [31:0] exp,
                       input logic [31:0] msk = 32'hffff_ffff);
    logic [31:0] v;
    bus(1'b0, idx, 32'h0, v);
    check(what, exp, v & msk);
  endtask

  task automatic edges(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (PROG_BLOCK !== 1'b0 && k < 2000) begin
      @(posedge CLK_SYS);
      k++;
    end
    edges(2);
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  // Strobe a read and look at the data register straight away
  task automatic t_read(input logic [7:0] a, input logic [7:0] exp);
    wr(nvmac_pkg::IDX_ADDR, {24'h0, a});
    halt_n = 0;
    rd_n = 0;
    wr(CTL, 32'h01);
    rdchk("read byte", nvmac_pkg::IDX_DATA, {24'h0, exp});
    edges(4);
    check("read halt", 32'h4, 32'(halt_n));
    check("read pulses", 32'h1, 32'(rd_n));
    rdchk("strobe readback", CTL, 32'h0);
  endtask

  // Arm then start; while busy, try mode, address and read changes
  task automatic t_prog(input logic [1:0] md, input int unsigned n, input logic [7:0] a, input logic [7:0] d);
    logic [31:0] w;
    w = {24'h0, 2'h0, md, 4'h8};
    GIE <= 1'b1; // Global flag on, so the ready level can only be held off by busy
    wr(nvmac_pkg::IDX_ADDR, {24'h0, a});
    wr(nvmac_pkg::IDX_DATA, {24'h0, d});
    wr(CTL, w);
    wr(CTL, w | 32'h4);
    halt_n = 0;
    blk_n = 0;
    rd_n = 0;
    wr(CTL, w | 32'h2);
    rdchk("busy word", CTL, w | 32'h2, NOARM);
    check("block", 32'h1, {31'h0, PROG_BLOCK});
    check("ready irq busy", 32'h0, {31'h0, READY_IRQ});
    wr(CTL, {24'h0, 2'h0, ~md, 4'h8});
    rdchk("mode kept", CTL, w | 32'h2, NOARM);
    wr(nvmac_pkg::IDX_ADDR, {24'h0, a ^ 8'h01});
    wr(CTL, w | 32'h1);
    wait_idle();
    check("busy length", 32'(n), 32'(blk_n));
    check("start halt", 32'h2, 32'(halt_n));
    check("read while busy", 32'h0, 32'(rd_n));
    check("ready irq idle", 32'h1, {31'h0, READY_IRQ});
    rdchk("addr kept", nvmac_pkg::IDX_ADDR, {24'h0, a});
    rdchk("idle word", CTL, w);
    rdchk("done status", nvmac_pkg::IDX_IRQ_STAT, 32'h1);
  endtask

  // Starts without a live arm, and the reserved mode, must all be refused
  task automatic t_refuse();
    wr(CTL, 32'h02);
    edges(2);
    check("no arm start", 32'h0, {31'h0, PROG_BLOCK});
    check("irq masked", 32'h0, {31'h0, IRQ});
    wr(nvmac_pkg::IDX_IRQ_MASK, 32'h2);
    edges(2);
    check("irq raised", 32'h1, {31'h0, IRQ});
    rdchk("refused status", nvmac_pkg::IDX_IRQ_STAT, 32'h2);
    edges(2);
    check("irq cleared", 32'h0, {31'h0, IRQ});
    wr(CTL, 32'h04);
    rdchk("arm set", CTL, 32'h04);
    edges(6);
    rdchk("arm lapsed", CTL, 32'h0);
    wr(CTL, 32'h02);
    edges(2);
    check("late start", 32'h0, {31'h0, PROG_BLOCK});
    wr(CTL, 32'h30);
    wr(CTL, 32'h34);
    wr(CTL, 32'h32);
    edges(2);
    check("reserved mode", 32'h0, {31'h0, PROG_BLOCK});
    rdchk("refused again", nvmac_pkg::IDX_IRQ_STAT, 32'h2);
    wr(nvmac_pkg::IDX_IRQ_MASK, 32'h0);
  endtask

  // Ready request follows enable and the global flag
  task automatic t_ready();
    GIE <= 1'b1;
    wr(CTL, 32'h08);
    edges(3);
    check("ready on", 32'h1, {31'h0, READY_IRQ});
    GIE <= 1'b0;
    edges(3);
    check("ready gie off", 32'h0, {31'h0, READY_IRQ});
    GIE <= 1'b1;
    wr(CTL, 32'h00);
    edges(3);
    check("ready disabled", 32'h0, {31'h0, READY_IRQ});
  endtask

  // Reset in mid-operation keeps the mode; reset when idle clears it
  task automatic t_rst_busy();
    wr(CTL, 32'h10);
    wr(CTL, 32'h14);
    wr(CTL, 32'h12);
    edges(2);
    RST_N <= 1'b0;
    edges(4);
    RST_N <= 1'b1;
    edges(3);
    check("busy through reset", 32'h1, {31'h0, PROG_BLOCK});
    rdchk("mode through reset", CTL, 32'h12);
    wait_idle();
    RST_N <= 1'b0;
    edges(4);
    RST_N <= 1'b1;
    edges(3);
    rdchk("mode after reset", CTL, 32'h0);
  endtask

  // Main sequence
  initial begin
    {HSEL, HWRITE, GIE, RST_N, POR_N} = 5'h0;
    {HTRANS, HSIZE, HADDR, HWDATA} = '0;
    {error_cnt, n_compared, cyc, halt_n, blk_n, rd_n} = '0;
    edges(16);
    RST_N <= 1'b1;
    POR_N <= 1'b1;
    edges(3);
    rdchk("reset word", CTL, 32'h0);
    rdchk("unmapped", 8'h30, 32'h0);
    rdchk("data reset", nvmac_pkg::IDX_DATA, {24'h0, nvmac_pkg::DATA_RESET});
    rdchk("mask reset", nvmac_pkg::IDX_IRQ_MASK, 32'h0);
    check("response", 32'h0, {31'h0, HRESP});
    wr(nvmac_pkg::IDX_ADDR, 32'hff);
    rdchk("addr top bit", nvmac_pkg::IDX_ADDR, 32'h7f);
    t_read(8'h15, 8'h15 ^ 8'h5a);
    t_prog(2'h1, SP, 8'h21, 8'h00);
    t_read(8'h21, 8'hff);
    t_prog(2'h2, SP, 8'h21, 8'h3c);
    t_read(8'h21, 8'h3c);
    t_prog(2'h0, AT, 8'h22, 8'ha5);
    t_read(8'h22, 8'ha5);
    t_refuse();
    t_ready();
    t_rst_busy();
    report_and_stop();
  end
endmodule

`default_nettype wire
